/* include/rps_params.svh */
// Timing, index and width constants of the rail power sequencer
`ifndef RPS_PARAMS_SVH
`define RPS_PARAMS_SVH
// System clock rate and the timebase tick
`define RPS_CLK_MHZ 20
`define RPS_TICK_US 1
`define RPS_DIV_W 5
// Timer width in microsecond ticks, wide enough for 4 s
`define RPS_TW 22
// Rail count and positions in the rail vectors
`define RPS_NRAIL 7
`define RPS_NOFF 6
`define RPS_IDX_KA 0
`define RPS_IDX_A 1
`define RPS_IDX_B 2
`define RPS_IDX_C 3
`define RPS_IDX_D 4
`define RPS_IDX_E 5
`define RPS_IDX_SYS 6
// Startup delays and soft-start times in microseconds
`define RPS_KA_DLY_US 400
`define RPS_KA_SS_US 400
`define RPS_A_DLY_US 32000
`define RPS_A_SS_US 100
`define RPS_BCD_DLY_US 2000
`define RPS_BCD_SS_US 400
`define RPS_E_DLY_US 0
`define RPS_E_SS_US 100
`define RPS_SYS_DLY_US 2000
`define RPS_SYS_SS_US 400
// Button long-press threshold and host reset release delay
`define RPS_LONG_PRESS_US 4000000
`define RPS_RST_DLY_US 40000
`endif

/* include/rps_pkg.sv */
// Types shared by the rail power sequencer
`include "rps_params.svh"
package rps_pkg;
    // One-hot rail sequencing states
    typedef enum logic [3:0] {
        RPS_OFF = 4'h1,
        RPS_DLY = 4'h2,
        RPS_RAMP = 4'h4,
        RPS_ON = 4'h8
    } rps_rail_st_t;

    // One rail: state and its microsecond timer
    typedef struct packed {
        rps_rail_st_t st;
        logic [`RPS_TW-1:0] cnt;
    } rps_rail_t;

    // Pin inputs as seen through the synchroniser
    typedef struct packed {
        logic uvlo;
        logic start;
        logic hold;
        logic sys_en;
        logic btn_n;
        logic [`RPS_NRAIL-1:0] pg;
    } rps_pins_t;

    // Rail controls toward the regulators
    typedef struct packed {
        logic [`RPS_NRAIL-1:0] enable;
        logic [`RPS_NRAIL-1:0] ramping;
    } rps_rails_out_t;

    // Whole state of the sequencer
    typedef struct packed {
        rps_pins_t meta;
        rps_pins_t pins;
        logic [`RPS_DIV_W-1:0] div;
        logic tick;
        rps_rail_t [`RPS_NRAIL-1:0] rail;
        logic latched;
        logic long_press;
        logic [`RPS_TW-1:0] btn_cnt;
        logic [`RPS_TW-1:0] rst_cnt;
        logic rst_n;
        rps_rails_out_t out;
    } rps_state_t;

    // Reset value: rails off, lockout assumed, button released
    function automatic rps_state_t rps_reset_value();
        rps_state_t s;
        s = '0;
        for (int i = 0; i < `RPS_NRAIL; i++) begin
            s.rail[i].st = RPS_OFF;
        end
        s.meta.uvlo = 1'b1;
        s.pins.uvlo = 1'b1;
        s.meta.btn_n = 1'b1;
        s.pins.btn_n = 1'b1;
        return s;
    endfunction
endpackage

/* rtl/rps_sequencer.sv */
// Rail power sequencer: keep-alive, cascaded chain, system rail, button and host reset
//
// Behaviour
// - Keep-alive rail on after lockout, 400+400 us
// - Chain start pin enables rail A, 32 ms
// - Rails B..E follow previous rail's regulation
// - Chain latched once A good and hold high
// - System rail from hold AND enable, delayed
// - System rail off when hold or enable low
// - Button held over 4 s drops chain
// - Hold low with start low drops chain
// - Short press pulses host reset, rails stay
// - Long press powers down every rail
// - Release after long press restarts sequence
// - Host reset released 40 ms after E good
`timescale 1ns/1ns
`include "rps_params.svh"

module rps_sequencer #(
    // Delays in microseconds; shorten them for simulation
    parameter logic [`RPS_TW-1:0] KA_DLY_US = `RPS_TW'(`RPS_KA_DLY_US),
    parameter logic [`RPS_TW-1:0] KA_SS_US = `RPS_TW'(`RPS_KA_SS_US),
    parameter logic [`RPS_TW-1:0] A_DLY_US = `RPS_TW'(`RPS_A_DLY_US),
    parameter logic [`RPS_TW-1:0] A_SS_US = `RPS_TW'(`RPS_A_SS_US),
    parameter logic [`RPS_TW-1:0] BCD_DLY_US = `RPS_TW'(`RPS_BCD_DLY_US),
    parameter logic [`RPS_TW-1:0] BCD_SS_US = `RPS_TW'(`RPS_BCD_SS_US),
    parameter logic [`RPS_TW-1:0] E_DLY_US = `RPS_TW'(`RPS_E_DLY_US),
    parameter logic [`RPS_TW-1:0] E_SS_US = `RPS_TW'(`RPS_E_SS_US),
    parameter logic [`RPS_TW-1:0] SYS_DLY_US = `RPS_TW'(`RPS_SYS_DLY_US),
    parameter logic [`RPS_TW-1:0] SYS_SS_US = `RPS_TW'(`RPS_SYS_SS_US),
    parameter logic [`RPS_TW-1:0] LONG_PRESS_US = `RPS_TW'(`RPS_LONG_PRESS_US),
    parameter logic [`RPS_TW-1:0] RST_DLY_US = `RPS_TW'(`RPS_RST_DLY_US)
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Board and host pins, asynchronous to clk_sys
    input wire logic input_undervoltage_lockout,
    input wire logic chain_start_pin,
    input wire logic power_hold_input,
    input wire logic system_rail_enable_input,
    input wire logic push_button_input_n,
    // Power-good of each rail from the analog side
    input wire logic [`RPS_NRAIL-1:0] rail_power_good,
    // Rail enables and soft-start indications
    output rps_pkg::rps_rails_out_t rails_out,
    // Enables of the regulators outside every sequence
    output logic [`RPS_NOFF-1:0] unsequenced_rail_enable,
    // Host processor reset
    output logic host_reset_out_n
);
    import rps_pkg::*;

    // How the block works as a whole:
    // - Every pin is asynchronous to clk_sys and passes two flip-flops, so a
    //   pin change reaches the logic two clocks after it settles.
    // - All timers count one-cycle microsecond enables from a single free-running
    //   divider. A delay of N ticks therefore lasts between N-1 and N microseconds,
    //   plus a few clocks; one shared divider was traded for that one-tick slack.
    // - Each rail runs its own small sequencer: off, startup delay, soft-start, on.
    //   Dropping its request returns it to off in one clock, without ramp-down.
    // - A long press overrides every request until the button is released, so the
    //   whole startup sequence runs again from the pins afterwards.
    // - Power-good of the keep-alive and system rails is synchronised with the rest
    //   but steers nothing; only chain rails gate their successors.
    // - The host reset is a plain level, held low until rail E has been good for
    //   the release delay; a short press restarts that delay.
    // - The hold latch keeps the chain on after the chain-start pin returns low;
    //   only a long press, or hold low with the pin low, clears it.
    // - The six regulators outside every sequence are tied off here; nothing in
    //   this block can turn them on.

    // Timebase tick period in system clocks, derived from the clock rate
    localparam int TICK_CYCLES = `RPS_CLK_MHZ * `RPS_TICK_US;
    localparam logic [`RPS_DIV_W-1:0] DIV_LAST = `RPS_DIV_W'(TICK_CYCLES - 1);
    localparam logic [`RPS_TW-1:0] ONE_TICK = `RPS_TW'(1);
    localparam rps_state_t ST_RST = rps_reset_value();

    // Per-rail startup delay and soft-start times
    // Rails B, C and D share one delay pair; rail E has no startup delay
    localparam logic [`RPS_TW-1:0] DLY_US [`RPS_NRAIL] = '{
        KA_DLY_US, A_DLY_US, BCD_DLY_US, BCD_DLY_US, BCD_DLY_US, E_DLY_US, SYS_DLY_US
    };
    localparam logic [`RPS_TW-1:0] SS_US [`RPS_NRAIL] = '{
        KA_SS_US, A_SS_US, BCD_SS_US, BCD_SS_US, BCD_SS_US, E_SS_US, SYS_SS_US
    };

    // Only state_reg holds flip-flops; everything below is combinational
    rps_state_t state_reg; // Registered state
    rps_state_t state_next; // Next state
    rps_pins_t pin_raw; // Pins gathered before the synchroniser
    logic [`RPS_NRAIL-1:0] rail_req; // Each rail's enable request
    rps_rail_t [`RPS_NRAIL-1:0] rail_next; // Each rail's next state
    logic btn_pressed; // Synchronised button is held down
    logic chain_run; // The cascaded chain is requested
    logic short_press; // Button released before long-press threshold

    // Advance one rail: off, startup delay, soft-start, on
    function automatic rps_rail_t rail_step(
        input rps_rail_t cur,
        input logic req,
        input logic tick,
        input logic [`RPS_TW-1:0] dly,
        input logic [`RPS_TW-1:0] ss
    );
        // Next rail state, starting from the current one
        rps_rail_t nx;
        nx = cur;
        if (!req) begin
            // Dropping the request disables the rail at once
            nx.st = RPS_OFF;
            nx.cnt = '0;
        end else begin
            unique case (cur.st)
                RPS_OFF: begin
                    // Request seen: the startup delay counts from zero
                    nx.st = RPS_DLY;
                    nx.cnt = '0;
                end
                RPS_DLY: begin
                    // A zero delay passes straight on to soft-start
                    if (cur.cnt >= dly) begin
                        // Delay over: enable rises together with the soft-start flag
                        nx.st = RPS_RAMP;
                        nx.cnt = '0;
                    end else if (tick) begin
                        nx.cnt = cur.cnt + ONE_TICK;
                    end
                end
                RPS_RAMP: begin
                    // Soft-start window; the regulator shapes the ramp itself
                    if (cur.cnt >= ss) begin
                        // Window over: enable stays, soft-start flag falls
                        nx.st = RPS_ON;
                        nx.cnt = '0;
                    end else if (tick) begin
                        nx.cnt = cur.cnt + ONE_TICK;
                    end
                end
                RPS_ON: begin
                    // Rail stays on for as long as its request stands
                    nx.cnt = '0;
                end
                default: begin
                    // An illegal code falls back to off
                    nx.st = RPS_OFF;
                    nx.cnt = '0;
                end
            endcase
        end
        return nx;
    endfunction

    // Pins into one bundle for the two-stage synchroniser
    assign pin_raw = '{
        uvlo: input_undervoltage_lockout,
        start: chain_start_pin,
        hold: power_hold_input,
        sys_en: system_rail_enable_input,
        btn_n: push_button_input_n,
        pg: rail_power_good
    };

    // Button is active low; pressed means the synchronised level is low
    assign btn_pressed = !state_reg.pins.btn_n;

    // Chain runs on the pin or the latch, never during a long press
    assign chain_run = (state_reg.pins.start || state_reg.latched) && !state_reg.long_press;

    // Release with some press time counted and no long press yet
    assign short_press = !btn_pressed && (state_reg.btn_cnt != '0) && !state_reg.long_press;

    // Requests: each chain rail after A waits for the previous rail's power-good
    always_comb begin
        rail_req = '0;
        // Keep-alive needs input power above lockout and no long press
        rail_req[`RPS_IDX_KA] = !state_reg.pins.uvlo && !state_reg.long_press;
        // Rail A starts from the pin or from the hold latch
        rail_req[`RPS_IDX_A] = chain_run;
        // Losing a power-good drops this rail and, through it, every later one
        rail_req[`RPS_IDX_B] = chain_run && state_reg.pins.pg[`RPS_IDX_A];
        rail_req[`RPS_IDX_C] = chain_run && state_reg.pins.pg[`RPS_IDX_B];
        rail_req[`RPS_IDX_D] = chain_run && state_reg.pins.pg[`RPS_IDX_C];
        // Rail E has no startup delay and starts on D's power-good while the chain runs
        rail_req[`RPS_IDX_E] = chain_run && state_reg.pins.pg[`RPS_IDX_D];
        // System rail follows the AND directly, so either input low kills it
        rail_req[`RPS_IDX_SYS] = state_reg.pins.hold && state_reg.pins.sys_en
            && !state_reg.long_press;
    end

    // One sequencer per rail, each with its own delay pair
    // The delay pairs are constants, so each copy folds to its own compares
    for (genvar i = 0; i < `RPS_NRAIL; i++) begin : g_rail
        assign rail_next[i] = rail_step(state_reg.rail[i], rail_req[i], state_reg.tick,
            DLY_US[i], SS_US[i]);
    end

    // Next-state logic for the whole block
    always_comb begin
        state_next = state_reg;
        // Fields not touched below keep their value

        // Synchroniser: first stage feeds only the second
        state_next.meta = pin_raw;
        state_next.pins = state_reg.meta;

        // Microsecond timebase as a one-cycle enable
        // The divider free-runs from reset and is never restarted by a request,
        // so the first tick of any delay may come after only one clock
        if (state_reg.div == DIV_LAST) begin
            state_next.div = '0;
            state_next.tick = 1'b1;
        end else begin
            // Count up between ticks
            state_next.div = state_reg.div + `RPS_DIV_W'(1);
            state_next.tick = 1'b0;
        end

        // Every rail advances each clock; the timers themselves wait for the tick
        state_next.rail = rail_next;

        // Button timing: a long press holds everything down until release
        if (btn_pressed) begin
            // Count held microseconds, stopping once a long press is seen
            if (state_reg.tick && !state_reg.long_press) begin
                // Long press only once the hold passes the threshold
                if (state_reg.btn_cnt >= LONG_PRESS_US) begin
                    state_next.long_press = 1'b1;
                end else begin
                    // Below threshold: keep counting
                    // The count stops at the threshold, so it never wraps while held
                    state_next.btn_cnt = state_reg.btn_cnt + ONE_TICK;
                end
            end
        end else begin
            // A short press is seen in this same cycle, from the count still held
            // Release clears the flag so the full sequence runs again
            state_next.btn_cnt = '0;
            state_next.long_press = 1'b0;
        end

        // Chain latch: set by rail A good with hold high
        // A long press wins over setting the latch, so a held button cannot re-latch
        if (state_next.long_press) begin
            state_next.latched = 1'b0;
        end else if (state_reg.latched && !state_reg.pins.hold && !state_reg.pins.start) begin
            // Hold dropped with the pin low: the host asks for the chain to stop
            state_next.latched = 1'b0;
        end else if (state_reg.pins.pg[`RPS_IDX_A] && state_reg.pins.hold
            && (state_reg.rail[`RPS_IDX_A].st == RPS_ON)) begin
            // Rail A on and good with hold high: latch the chain
            state_next.latched = 1'b1;
        end

        // Host reset: held low until rail E has been good for the delay
        if (!state_reg.pins.pg[`RPS_IDX_E] || (state_reg.rail[`RPS_IDX_E].st != RPS_ON)
            || short_press) begin
            // A short press restarts the delay; rails are untouched
            state_next.rst_cnt = '0;
            state_next.rst_n = 1'b0;
        end else if (state_reg.rst_cnt >= RST_DLY_US) begin
            // Delay has run: release the host, the count holds here
            state_next.rst_n = 1'b1;
        end else begin
            // Still counting: the host stays in reset
            state_next.rst_n = 1'b0;
            // Count only on the timebase enable
            if (state_reg.tick) begin
                state_next.rst_cnt = state_reg.rst_cnt + ONE_TICK;
            end
        end

        // Registered rail controls decoded from the next rail states
        // Decoding from the next state keeps the outputs in step with the rail state
        for (int j = 0; j < `RPS_NRAIL; j++) begin
            state_next.out.enable[j] = (rail_next[j].st == RPS_RAMP) || (rail_next[j].st == RPS_ON);
            state_next.out.ramping[j] = (rail_next[j].st == RPS_RAMP);
        end
    end

    // State register with asynchronous reset to constants only
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            // Rails off, host reset low, pins as if power were absent
            state_reg <= ST_RST;
        end else begin
            // Otherwise take the next state
            state_reg <= state_next;
        end
    end

    // Outputs straight from the state register
    // No logic sits between these flip-flops and the pins
    assign rails_out = state_reg.out;
    assign host_reset_out_n = state_reg.rst_n;

    // Rails outside every sequence stay disabled
    // Any later control of these rails lives outside this block
    assign unsequenced_rail_enable = `RPS_NOFF'(0);

endmodule // rps_sequencer

/* testbench/rps_properties.sv */
// Concurrent checks on the ports of the rail power sequencer
`timescale 1ns/1ns
`include "rps_params.svh"
module rps_properties import rps_pkg::*; #(
    parameter logic [`RPS_TW-1:0] KA_DLY_US = 22'h4,
    parameter logic [`RPS_TW-1:0] LONG_PRESS_US = 22'h1E,
    parameter logic [`RPS_TW-1:0] RST_DLY_US = 22'hA
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Board pins
    input wire logic input_undervoltage_lockout,
    input wire logic chain_start_pin,
    input wire logic power_hold_input,
    input wire logic system_rail_enable_input,
    input wire logic push_button_input_n,
    input wire logic [`RPS_NRAIL-1:0] rail_power_good,
    // Sequencer outputs
    input rps_rails_out_t rails_out,
    input wire logic [`RPS_NOFF-1:0] unsequenced_rail_enable,
    input wire logic host_reset_out_n
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // Runs of power ok, rail E good and button held, in cycles
    // The design's free-running tick may shorten a delay by up to one tick
    int ka_cnt;
    int pg_cnt;
    int btn_cnt;
    // A press restarts the keep-alive count, since a long press drops that rail
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ka_cnt <= 0;
            pg_cnt <= 0;
            btn_cnt <= 0;
        end else begin
            ka_cnt <= (input_undervoltage_lockout || !push_button_input_n) ? 0 : ka_cnt + 1;
            pg_cnt <= rail_power_good[`RPS_IDX_E] ? pg_cnt + 1 : 0;
            btn_cnt <= push_button_input_n ? 0 : btn_cnt + 1;
        end
    end
    // System rail gate held low long enough to pass the synchroniser
    sequence s_gate_low;
        (!(power_hold_input && system_rail_enable_input))[*5];
    endsequence
    // A press of at least two ticks, then release
    sequence s_short_press;
        (!push_button_input_n && btn_cnt > 40) ##1 push_button_input_n;
    endsequence
    AST_UNSEQ_OFF: assert property (unsequenced_rail_enable == '0)
        else $error("unsequenced rail enabled");
    AST_KA_DELAY: assert property ($rose(rails_out.enable[`RPS_IDX_KA]) |->
        ka_cnt >= (KA_DLY_US - 1) * 20 && ka_cnt <= (KA_DLY_US + 2) * 20) else $error("keep-alive delay wrong");
    AST_KA_RAMP: assert property ($rose(rails_out.enable[`RPS_IDX_KA]) |-> rails_out.ramping[`RPS_IDX_KA])
        else $error("keep-alive skipped soft-start");
    AST_B_GATED: assert property ((!rail_power_good[`RPS_IDX_A])[*5] |-> !rails_out.enable[`RPS_IDX_B])
        else $error("rail B on without rail A good");
    AST_E_GATED: assert property ((!rail_power_good[`RPS_IDX_D])[*5] |-> !rails_out.enable[`RPS_IDX_E])
        else $error("rail E on without rail D good");
    AST_SYS_GATE: assert property (s_gate_low |-> !rails_out.enable[`RPS_IDX_SYS])
        else $error("system rail on with gate low");
    AST_LONG_DROP: assert property (btn_cnt > (LONG_PRESS_US + 2) * 20 |-> rails_out.enable == '0)
        else $error("long press left a rail on");
    AST_SHORT_RESET: assert property (s_short_press |-> ##[1:8] !host_reset_out_n)
        else $error("short press gave no host reset");
    AST_RST_DELAY: assert property ($rose(host_reset_out_n) |-> pg_cnt >= (RST_DLY_US - 1) * 20)
        else $error("host reset released early");
    AST_RST_GATED: assert property ((!rail_power_good[`RPS_IDX_E])[*5] |-> !host_reset_out_n)
        else $error("host reset high without rail E");
endmodule // rps_properties

bind rps_sequencer rps_properties #(.KA_DLY_US(KA_DLY_US), .LONG_PRESS_US(LONG_PRESS_US),
    .RST_DLY_US(RST_DLY_US)) u_rps_properties (.clk_sys(clk_sys), .rstn(rstn),
    .input_undervoltage_lockout(input_undervoltage_lockout), .chain_start_pin(chain_start_pin),
    .power_hold_input(power_hold_input), .system_rail_enable_input(system_rail_enable_input),
    .push_button_input_n(push_button_input_n), .rail_power_good(rail_power_good), .rails_out(rails_out),
    .unsequenced_rail_enable(unsequenced_rail_enable), .host_reset_out_n(host_reset_out_n));

/* testbench/rps_board_model.sv */
// Analog side of the regulators and the hold pull-up, as seen by the sequencer
`timescale 1ns/1ns
`include "rps_params.svh"
module rps_board_model import rps_pkg::*; (
    // Clock
    input wire logic clk_sys,
    // Regulator controls
    input rps_rails_out_t rails_out,
    // Host pulls the hold line low
    input wire logic host_hold_low,
    // Status back to the sequencer
    output logic [`RPS_NRAIL-1:0] rail_power_good,
    output logic power_hold_input
);
    logic [`RPS_NRAIL-1:0] settle_reg;
    // Good only a while after soft-start ends; drops at once when disabled
    always @(posedge clk_sys) begin
        settle_reg <= rails_out.enable & ~rails_out.ramping;
        rail_power_good <= settle_reg & rails_out.enable;
    end
    // Hold is pulled up from rail A, so it cannot be high before A is good
    assign power_hold_input = rail_power_good[`RPS_IDX_A] & ~host_hold_low;
endmodule // rps_board_model

/* testbench/tb_top.sv */
// Self-checking bench of the rail power sequencer
`timescale 1ns/1ns
`include "rps_params.svh"
module tb_top;
    import rps_pkg::*;
    // Shortened delays in ticks of 20 cycles
    localparam int TK = 20;
    localparam logic [`RPS_TW-1:0] KA = 22'h4, AD = 22'h6, BD = 22'h3, SD = 22'h3, SS = 22'h2;
    localparam logic [`RPS_TW-1:0] LP = 22'h1E, RD = 22'hA;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    // Pins driven by the bench
    logic uvlo = 1'b1, start = 1'b0, sys_en = 1'b0, btn_n = 1'b1, hold_low = 1'b0, v;
    logic hold, rst_n;
    logic [`RPS_NRAIL-1:0] pg;
    logic [`RPS_NOFF-1:0] unseq;
    rps_rails_out_t rails;
    int miscompares = 0, n_compared = 0, cyc_cnt = 0, t0 = 0;
    int rise_at [`RPS_NRAIL];
    always #25 clk_sys = ~clk_sys;
    rps_sequencer #(.KA_DLY_US(KA), .KA_SS_US(SS), .A_DLY_US(AD), .A_SS_US(SS), .BCD_DLY_US(BD),
        .BCD_SS_US(SS), .E_DLY_US(22'h0), .E_SS_US(SS), .SYS_DLY_US(SD), .SYS_SS_US(SS),
        .LONG_PRESS_US(LP), .RST_DLY_US(RD)) u_rps_sequencer (.clk_sys(clk_sys), .rstn(rstn),
        .input_undervoltage_lockout(uvlo), .chain_start_pin(start), .power_hold_input(hold),
        .system_rail_enable_input(sys_en), .push_button_input_n(btn_n), .rail_power_good(pg),
        .rails_out(rails), .unsequenced_rail_enable(unseq), .host_reset_out_n(rst_n));
    rps_board_model u_rps_board_model (.clk_sys(clk_sys), .rails_out(rails), .host_hold_low(hold_low),
        .rail_power_good(pg), .power_hold_input(hold));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // Bounded wait for a rail to report good
    task automatic wait_good(input int idx);
        for (int n = 0; n < 3000 && pg[idx] !== 1'b1; n++) begin
            cyc(1);
        end
        check({7'h0, pg[idx]}, 8'h01, "rail never good");
    endtask
    // Expected system rail once its delay has run
    function automatic logic exp_sys(input logic h, input logic e);
        return h & e;
    endfunction
    // One when the later rise came at least d ticks after the earlier, less the tick's phase
    function automatic logic [7:0] gap_ok(input int a, input int b, input logic [`RPS_TW-1:0] d);
        return {7'h0, (b - a) >= (int'(d) - 1) * TK};
    endfunction
    // One when a delay from its pin ended within d+1 ticks and the synchroniser
    function automatic logic [7:0] gap_max(input int a, input int b, input logic [`RPS_TW-1:0] d);
        return {7'h0, (b - a) <= (int'(d) + 1) * TK + 8};
    endfunction
    // First rise of each enable; a hang is cut short here
    always @(posedge clk_sys) begin
        cyc_cnt <= cyc_cnt + 1;
        for (int i = 0; i < `RPS_NRAIL; i++) begin
            if (rails.enable[i] === 1'b1 && rise_at[i] == 0) begin
                rise_at[i] <= cyc_cnt;
            end
        end
        if (cyc_cnt == 20000) begin
            miscompares++;
            give_verdict();
        end
    end
    initial begin
        void'($urandom(32'hE1A6));
        cyc(3);
        rstn = 1'b1;
        uvlo = 1'b0;
        t0 = cyc_cnt;
        check({1'b0, rails.enable}, 8'h00, "rails on before delay");
        check({2'b0, unseq}, 8'h00, "unsequenced rail on");
        wait_good(`RPS_IDX_KA);
        check(gap_ok(t0, rise_at[0], KA), 8'h01, "keep-alive early");
        check(gap_max(t0, rise_at[0], KA), 8'h01, "keep-alive late");
        start = 1'b1;
        t0 = cyc_cnt;
        wait_good(`RPS_IDX_E);
        check(gap_ok(t0, rise_at[1], AD), 8'h01, "rail A early");
        check(gap_max(t0, rise_at[1], AD), 8'h01, "rail A late");
        for (int i = 1; i < 4; i++) begin
            check(gap_ok(rise_at[i], rise_at[i + 1], BD), 8'h01, "chain order");
        end
        check(gap_ok(rise_at[4], rise_at[5], SS), 8'h01, "rail E before D good");
        check({7'h0, rst_n}, 8'h00, "host reset released early");
        cyc(RD * TK + 80);
        check({7'h0, rst_n}, 8'h01, "host reset stuck low");
        start = 1'b0;
        cyc(60);
        check({3'b0, rails.enable[5:1]}, 8'h1F, "chain not latched");
        // Enable only now that the chain is good, then toggle at random
        for (int k = 0; k < 6; k++) begin
            v = 1'($urandom_range(1, 0));
            sys_en = v;
            cyc(v ? 200 : 6);
            check({7'h0, rails.enable[6]}, {7'h0, exp_sys(hold, v)}, "system rail");
        end
        sys_en = 1'b1;
        cyc(200);
        btn_n = 1'b0;
        cyc($urandom_range(300, 60));
        btn_n = 1'b1;
        cyc(8);
        check({7'h0, rst_n}, 8'h00, "short press gave no reset");
        check({1'b0, rails.enable}, 8'h7F, "short press moved rails");
        start = 1'b1;
        btn_n = 1'b0;
        cyc((LP + 3) * TK);
        check({1'b0, rails.enable}, 8'h00, "long press left rails on");
        btn_n = 1'b1;
        wait_good(`RPS_IDX_E);
        wait_good(`RPS_IDX_KA);
        start = 1'b0;
        cyc(20);
        hold_low = 1'b1;
        cyc(40);
        check({1'b0, rails.enable}, 8'h01, "hold drop left rails on");
        give_verdict();
    end
endmodule // tb_top
